// ===== rtl/xfer_addr_step.sv
// Pointer stepper: adds one or two to a 16-bit address when enabled.
`timescale 1ns/10ps
`default_nettype none
module xfer_addr_step (
	input wire logic [15:0] addrIn,
	input wire logic stepEn,
	input wire logic isByte,
	output logic [15:0] addrOut
);
	// Plain 16-bit wrap; addresses are never window-remapped.
	always_comb begin
		if (stepEn) begin
			addrOut = addrIn + (isByte ? 16'h0001 : 16'h0002);
		end else begin
			addrOut = addrIn;
		end
	end
endmodule : xfer_addr_step
`default_nettype wire

// ===== rtl/xfer_req_pick.sv
// Priority picker of the highest eligible interrupt source.
`timescale 1ns/10ps
`default_nettype none
module xfer_req_pick #(
	parameter int N = 16
) (
	input wire logic [N-1:0] eligible,
	output logic any,
	output logic [3:0] index
);
	// Higher index wins, mirroring fixed hardware priority.
	always_comb begin
		any = 1'b0;
		index = 4'h0;
		for (int i = 0; i < N; i++) begin
			if (eligible[i]) begin
				any = 1'b1;
				index = 4'(i);
			end
		end
	end
endmodule : xfer_req_pick

// ===== rtl/xfer_server.sv
// Interrupt-triggered block-transfer server with register port and memory bus.
`timescale 1ns/10ps
`default_nettype none
module xfer_server #(
	parameter int NSRC = xfer_server_pkg::NUM_SOURCES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [NSRC-1:0] intReq,
	input wire logic instrDone,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	output xfer_server_pkg::mem_req_type memReq,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	output logic busy,
	output logic irq
);
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_WAIT = 10'h002,
		ST_RCNT = 10'h004,
		ST_RCTL = 10'h008,
		ST_RSRC = 10'h010,
		ST_RDST = 10'h020,
		ST_RBST = 10'h040,
		ST_MOVR = 10'h080,
		ST_MOVW = 10'h100,
		ST_WBCK = 10'h200
	} state_type;

	state_type state_r, state_nxt;
	logic [NSRC-1:0] select_r, select_nxt, pend_r, pend_nxt, mask_r, mask_nxt;
	logic [NSRC-1:0] latch_r, latch_nxt;
	logic glbIe_r, glbIe_nxt, srvEn_r, srvEn_nxt;
	logic [15:0] vec_r [NSRC];
	logic [3:0] src_r, src_nxt;
	logic [15:0] base_r, base_nxt, sp_r, sp_nxt, dp_r, dp_nxt, data_r, data_nxt;
	logic [7:0] cnt_r, cnt_nxt, ctl_r, ctl_nxt;
	logic [5:0] left_r, left_nxt;
	logic [1:0] wbStep_r, wbStep_nxt;
	logic [2:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
	logic [15:0] rdata_nxt;
	xfer_server_pkg::mem_req_type req_nxt;
	logic anyReq;
	logic [3:0] pickIdx;
	logic [15:0] spStep, dpStep;
	logic [NSRC-1:0] eligible, ccMask;
	logic isByte, burstEnd;
	// One-cycle set events, kept apart so that a clear in the same cycle
	// cannot hide them.
	logic [NSRC-1:0] pendSet;
	logic [2:0] istSet;

	// The shared capture/compare vector is masked out of server triggers.
	always_comb begin
		ccMask = '1;
		ccMask[xfer_server_pkg::CAPTURE_COMPARE_SHARED_INTERRUPT] = 1'b0;
	end
	// Eligibility needs mask, select and both global enables.
	assign eligible = latch_r & mask_r & select_r & ccMask
		& {NSRC{glbIe_r & srvEn_r}};

	xfer_req_pick #(.N(NSRC)) picker (
		.eligible(eligible),
		.any(anyReq),
		.index(pickIdx)
	);

	assign isByte = ctl_r[xfer_server_pkg::CTRL_BYTE_BIT];

	xfer_addr_step srcStep (
		.addrIn(sp_r),
		.stepEn(ctl_r[xfer_server_pkg::CTRL_SRC_STEP_BIT]),
		.isByte(isByte),
		.addrOut(spStep)
	);
	xfer_addr_step dstStep (
		.addrIn(dp_r),
		.stepEn(ctl_r[xfer_server_pkg::CTRL_DST_STEP_BIT]),
		.isByte(isByte),
		.addrOut(dpStep)
	);

	assign burstEnd = (left_r == 6'h01);
	assign busy = (state_r != ST_IDLE);
	assign irq = |(ist_r & imsk_r);

	// Sequencer: fetches the control block, runs the burst, writes back.
	always_comb begin
		state_nxt = state_r;
		src_nxt = src_r;
		base_nxt = base_r;
		sp_nxt = sp_r;
		dp_nxt = dp_r;
		data_nxt = data_r;
		cnt_nxt = cnt_r;
		ctl_nxt = ctl_r;
		left_nxt = left_r;
		wbStep_nxt = wbStep_r;
		select_nxt = select_r;
		pend_nxt = pend_r;
		latch_nxt = latch_r | intReq;
		ist_nxt = ist_r;
		req_nxt = '0;
		pendSet = '0;
		istSet = '0;
		unique case (state_r)
			ST_IDLE: begin
				if (anyReq) begin
					src_nxt = pickIdx;
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Held off until the running instruction retires.
				if (instrDone) begin
					// Block base forced to a quad-word boundary.
					base_nxt = {vec_r[src_r][15:3], 3'h0};
					// A request that arrives now is kept for the next service.
					latch_nxt[src_r] = intReq[src_r];
					state_nxt = ST_RCNT;
				end
			end
			ST_RCNT, ST_RCTL, ST_RSRC, ST_RDST, ST_RBST: begin
				req_nxt.read = 1'b1;
				req_nxt.isByte = (state_r == ST_RCNT) || (state_r == ST_RCTL)
					|| (state_r == ST_RBST);
				unique case (state_r)
					ST_RCNT: req_nxt.addr = base_r + xfer_server_pkg::CB_COUNT_OFS;
					ST_RCTL: req_nxt.addr = base_r + xfer_server_pkg::CB_CTRL_OFS;
					ST_RSRC: req_nxt.addr = base_r + xfer_server_pkg::CB_SRC_OFS;
					ST_RDST: req_nxt.addr = base_r + xfer_server_pkg::CB_DST_OFS;
					default: req_nxt.addr = base_r + xfer_server_pkg::CB_BURST_OFS;
				endcase
				if (memAck) begin
					req_nxt = '0;
					unique case (state_r)
						ST_RCNT: begin
							cnt_nxt = memRdata[7:0];
							state_nxt = ST_RCTL;
						end
						ST_RCTL: begin
							ctl_nxt = memRdata[7:0];
							state_nxt = ST_RSRC;
						end
						ST_RSRC: begin
							sp_nxt = memRdata;
							state_nxt = ST_RDST;
						end
						ST_RDST: begin
							dp_nxt = memRdata;
							state_nxt = ST_RBST;
						end
						default: begin
							// Zero or over 32 is clamped to a legal burst.
							if (memRdata[7:0] == 8'h00) begin
								left_nxt = 6'h01;
							end else if (memRdata[7:0] > 8'(xfer_server_pkg::MAX_BURST)) begin
								left_nxt = 6'(xfer_server_pkg::MAX_BURST);
							end else begin
								left_nxt = memRdata[5:0];
							end
							// Only block mode is built; other modes end at once.
							if (ctl_r[xfer_server_pkg::CTRL_MODE_HI:
								xfer_server_pkg::CTRL_MODE_LO]
								== xfer_server_pkg::MODE_BLOCK) begin
								state_nxt = ST_MOVR;
							end else begin
								state_nxt = ST_IDLE;
							end
						end
					endcase
				end
			end
			ST_MOVR: begin
				req_nxt.read = 1'b1;
				req_nxt.isByte = isByte;
				req_nxt.addr = sp_r;
				if (memAck) begin
					req_nxt = '0;
					data_nxt = memRdata;
					state_nxt = ST_MOVW;
				end
			end
			ST_MOVW: begin
				req_nxt.write = 1'b1;
				req_nxt.isByte = isByte;
				req_nxt.addr = dp_r;
				req_nxt.wdata = data_r;
				if (memAck) begin
					req_nxt = '0;
					sp_nxt = spStep;
					dp_nxt = dpStep;
					left_nxt = left_r - 6'h01;
					// No exit to idle until the burst is done.
					if (burstEnd) begin
						cnt_nxt = cnt_r - 8'h01;
						wbStep_nxt = 2'h0;
						state_nxt = ST_WBCK;
					end else begin
						state_nxt = ST_MOVR;
					end
				end
			end
			ST_WBCK: begin
				// Step 0 count, 1 source, 2 destination.
				req_nxt.write = (wbStep_r == 2'h0)
					|| (wbStep_r == 2'h1 && ctl_r[xfer_server_pkg::CTRL_SRC_WB_BIT])
					|| (wbStep_r == 2'h2
					&& ctl_r[xfer_server_pkg::CTRL_DST_WB_BIT]);
				req_nxt.isByte = (wbStep_r == 2'h0);
				unique case (wbStep_r)
					2'h0: begin
						req_nxt.addr = base_r + xfer_server_pkg::CB_COUNT_OFS;
						req_nxt.wdata = {8'h00, cnt_r};
					end
					2'h1: begin
						req_nxt.addr = base_r + xfer_server_pkg::CB_SRC_OFS;
						req_nxt.wdata = sp_r;
					end
					default: begin
						req_nxt.addr = base_r + xfer_server_pkg::CB_DST_OFS;
						req_nxt.wdata = dp_r;
					end
				endcase
				if (memAck || !req_nxt.write) begin
					req_nxt = '0;
					wbStep_nxt = wbStep_r + 2'h1;
					if (wbStep_r == 2'h2) begin
						state_nxt = ST_IDLE;
						if (cnt_r == 8'h00) begin
							select_nxt[src_r] = 1'b0;
							pend_nxt[src_r] = 1'b1;
							pendSet[src_r] = 1'b1;
							ist_nxt[0] = 1'b1;
							istSet[0] = 1'b1;
						end
						ist_nxt[1] = 1'b1;
						istSet[1] = 1'b1;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Register port: writes, read-to-clear interrupt status.
	always_comb begin
		mask_nxt = mask_r;
		glbIe_nxt = glbIe_r;
		srvEn_nxt = srvEn_r;
		imsk_nxt = imsk_r;
		rdata_nxt = xfer_server_pkg::RESET_WORD;
		if (regWr) begin
			unique case (regAddr)
				xfer_server_pkg::REG_MASK: mask_nxt = NSRC'(regWdata);
				xfer_server_pkg::REG_CONTROL: begin
					glbIe_nxt = regWdata[0];
					srvEn_nxt = regWdata[1];
				end
				xfer_server_pkg::REG_IRQ_MASK: imsk_nxt = regWdata[2:0];
				default: ;
			endcase
		end
		if (regRd) begin
			unique case (regAddr)
				xfer_server_pkg::REG_SELECT: rdata_nxt = 16'(select_r);
				xfer_server_pkg::REG_PENDING: rdata_nxt = 16'(pend_r);
				xfer_server_pkg::REG_MASK: rdata_nxt = 16'(mask_r);
				xfer_server_pkg::REG_CONTROL: rdata_nxt = {14'h0000, srvEn_r, glbIe_r};
				xfer_server_pkg::REG_STATUS: rdata_nxt = {11'h000, src_r, busy};
				xfer_server_pkg::REG_IRQ_STAT: rdata_nxt = {13'h0000, ist_r};
				xfer_server_pkg::REG_IRQ_MASK: rdata_nxt = {13'h0000, imsk_r};
				default: rdata_nxt = xfer_server_pkg::RESET_WORD;
			endcase
		end
	end

	// Final merge of software and hardware updates; hardware update wins.
	logic [NSRC-1:0] selFin, pendFin;
	logic [2:0] istFin;
	always_comb begin
		selFin = select_nxt;
		pendFin = pend_nxt;
		istFin = ist_nxt;
		if (regWr && regAddr == xfer_server_pkg::REG_SELECT) begin
			selFin = NSRC'(regWdata);
			// A clear by the end of the last burst wins over software.
			if (select_nxt != select_r) begin
				selFin = NSRC'(regWdata) & select_nxt;
			end
		end
		if (regWr && regAddr == xfer_server_pkg::REG_PENDING) begin
			pendFin = (pend_r & ~NSRC'(regWdata)) | pendSet;
		end
		if (regRd && regAddr == xfer_server_pkg::REG_IRQ_STAT) begin
			istFin = istSet;
		end
	end

	// Vector table is written through the register port.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NSRC; i++) begin
				vec_r[i] <= xfer_server_pkg::RESET_WORD;
			end
		end else if (regWr && regAddr == xfer_server_pkg::REG_VEC_BASE) begin
			vec_r[regWdata[15:12]] <= {4'h0, regWdata[11:0]};
		end
	end

	// State registers.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			select_r <= '0;
			pend_r <= '0;
			mask_r <= '0;
			latch_r <= '0;
			glbIe_r <= 1'b0;
			srvEn_r <= 1'b0;
			src_r <= 4'h0;
			base_r <= xfer_server_pkg::RESET_WORD;
			sp_r <= xfer_server_pkg::RESET_WORD;
			dp_r <= xfer_server_pkg::RESET_WORD;
			data_r <= xfer_server_pkg::RESET_WORD;
			cnt_r <= 8'h00;
			ctl_r <= 8'h00;
			left_r <= 6'h00;
			wbStep_r <= 2'h0;
			ist_r <= 3'h0;
			imsk_r <= 3'h0;
			regRdata <= xfer_server_pkg::RESET_WORD;
			memReq <= '0;
		end else begin
			state_r <= state_nxt;
			select_r <= selFin;
			pend_r <= pendFin;
			mask_r <= mask_nxt;
			latch_r <= latch_nxt;
			glbIe_r <= glbIe_nxt;
			srvEn_r <= srvEn_nxt;
			src_r <= src_nxt;
			base_r <= base_nxt;
			sp_r <= sp_nxt;
			dp_r <= dp_nxt;
			data_r <= data_nxt;
			cnt_r <= cnt_nxt;
			ctl_r <= ctl_nxt;
			left_r <= left_nxt;
			wbStep_r <= wbStep_nxt;
			ist_r <= istFin;
			imsk_r <= imsk_nxt;
			regRdata <= rdata_nxt;
			memReq <= req_nxt;
		end
	end
endmodule : xfer_server
`default_nettype wire

// ===== rtl/xfer_server_pkg.sv
// Package with constants and types of the interrupt block-transfer server.
// What this block does
// - Mode bits 7..5 all zero select block mode: a burst per request.
// - After each transfer of a burst, step each pointer only if its step bit set.
// - After a burst decrement cycle count; write back source if its flag set.
// - Destination flag clear leaves stored destination pointer unchanged.
// - Count reaching zero clears select bit and sets done-pending bit.
// - Any selected source triggers, except the shared capture/compare vector.
// - Start only after current instruction completes; worst latency 43 states.
// - A started burst is never interrupted; other requests wait.
// - Pointers are plain 16-bit addresses with no window remapping.
// - Serve requests with mask and select set, interrupts and server enabled.
// - Vector addresses block: count, control, source word, destination word.
// - Control byte: mode 7..5, size 4, write-back 3..2, step 1..0.
// - Burst count byte gives transfers per request, at most 32.
package xfer_server_pkg;

	// Control block byte offsets from the block base.
	localparam logic [15:0] CB_COUNT_OFS = 16'h0000;
	localparam logic [15:0] CB_CTRL_OFS = 16'h0001;
	localparam logic [15:0] CB_SRC_OFS = 16'h0002;
	localparam logic [15:0] CB_DST_OFS = 16'h0004;
	localparam logic [15:0] CB_BURST_OFS = 16'h0006;

	// Control byte field positions.
	localparam int CTRL_MODE_HI = 7;
	localparam int CTRL_MODE_LO = 5;
	localparam int CTRL_BYTE_BIT = 4;
	localparam int CTRL_SRC_WB_BIT = 3;
	localparam int CTRL_DST_WB_BIT = 2;
	localparam int CTRL_SRC_STEP_BIT = 1;
	localparam int CTRL_DST_STEP_BIT = 0;
	localparam logic [2:0] MODE_BLOCK = 3'h0;

	localparam int MAX_BURST = 32;
	localparam int NUM_SOURCES = 16;
	// Source index of the shared capture/compare interrupt; never served.
	localparam int CAPTURE_COMPARE_SHARED_INTERRUPT = 0;
	localparam int EXTERNAL_INTERRUPT_INPUT = 14;

	// Worst latency in state times and the clock count derived from it.
	localparam int LATENCY_STATES = 43;
	localparam int CYCLES_PER_STATE = 1;
	localparam int LATENCY_CYCLES = LATENCY_STATES * CYCLES_PER_STATE;

	// Register port addresses.
	localparam logic [3:0] REG_SELECT = 4'h0;
	localparam logic [3:0] REG_PENDING = 4'h1;
	localparam logic [3:0] REG_MASK = 4'h2;
	localparam logic [3:0] REG_CONTROL = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT = 4'h5;
	localparam logic [3:0] REG_IRQ_MASK = 4'h6;
	localparam logic [3:0] REG_VEC_BASE = 4'h8;

	localparam logic [15:0] RESET_WORD = 16'h0000;

	// Memory request toward the system bus.
	typedef struct packed {
		logic read;
		logic write;
		logic isByte;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_type;

endpackage : xfer_server_pkg

// ===== testbench/xfer_mem_model.sv
// Memory partner answering the server's bus requests.
`timescale 1ns/10ps
`default_nettype none
module xfer_mem_model (
	input wire logic ref_clk,
	input wire xfer_server_pkg::mem_req_type memReq,
	input wire logic [3:0] lag,
	output logic memAck,
	output logic [15:0] memRdata
);
	// Flat byte array over the whole 16-bit space; no window remapping.
	logic [7:0] mem [0:65535];
	logic [3:0] cnt;
	initial begin
		memAck = 1'h0;
		memRdata = 16'h0;
		cnt = 4'h0;
	end
	// One ack per request after lag cycles; data toggles outside the ack
	// so a stale value is never mistaken for a fresh one.
	always @(posedge ref_clk) begin
		memAck <= 1'h0;
		memRdata <= ~memRdata;
		if ((memReq.read || memReq.write) && !memAck) begin
			cnt <= cnt + 4'h1;
			if (cnt >= lag) begin
				cnt <= 4'h0;
				memAck <= 1'h1;
				if (memReq.read && memReq.isByte) memRdata <= {8'h0, mem[memReq.addr]};
				else if (memReq.read) memRdata <= {mem[memReq.addr + 16'h1], mem[memReq.addr]};
				else mem[memReq.addr] = memReq.wdata[7:0];
				if (memReq.write && !memReq.isByte) mem[memReq.addr + 16'h1] = memReq.wdata[15:8];
			end
		end
	end
endmodule : xfer_mem_model
`default_nettype wire

// ===== testbench/xfer_server_properties.sv
// Port checker of the transfer server.
`timescale 1ns/10ps
`default_nettype none
module xfer_server_properties (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic instrDone,
	input wire logic regRd,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regRdata,
	input wire xfer_server_pkg::mem_req_type memReq,
	input wire logic memAck,
	input wire logic busy
);
	logic act;
	logic first_r;
	logic first_nxt;
	logic done_r;
	logic done_nxt;
	assign act = memReq.read | memReq.write;
	// Mark the first request of a service and whether the instruction ended.
	always_comb begin
		first_nxt = !busy | (first_r & !act);
		done_nxt = busy & (done_r | instrDone);
	end
	// Registers of the helper flags.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			first_r <= 1'h1;
			done_r <= 1'h0;
		end else begin
			first_r <= first_nxt;
			done_r <= done_nxt;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_hold;
		act && !memAck |=> $stable(memReq);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request changed before ack");
	property p_drop;
		memAck |=> !act;
	endproperty
	a_drop: assert property (p_drop)
		else $error("request kept after ack");
	property p_excl;
		!(memReq.read && memReq.write);
	endproperty
	a_excl: assert property (p_excl)
		else $error("read and write together");
	property p_busy;
		act |-> busy;
	endproperty
	a_busy: assert property (p_busy)
		else $error("request while idle");
	property p_first;
		first_r && act |-> memReq.read && memReq.isByte
			&& memReq.addr[1:0] == 2'h0;
	endproperty
	a_first: assert property (p_first)
		else $error("first fetch not count byte");
	property p_seen;
		act |-> done_r;
	endproperty
	a_seen: assert property (p_seen)
		else $error("start before instruction end");
	property p_lat;
		busy && instrDone && !done_r |-> ##[1:43] memReq.read;
	endproperty
	a_lat: assert property (p_lat)
		else $error("start latency too long");
	property p_unmap;
		regRd && (regAddr == 4'h7 || regAddr > 4'h8) |=> regRdata == 16'h0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
endmodule : xfer_server_properties
bind xfer_server xfer_server_properties i_xfer_server_properties (
	.ref_clk(ref_clk), .rstn(rstn), .instrDone(instrDone), .regRd(regRd),
	.regAddr(regAddr), .regRdata(regRdata), .memReq(memReq),
	.memAck(memAck), .busy(busy));
`default_nettype wire

// ===== testbench/xfer_server_tb_top.sv
// Testbench of the interrupt block-transfer server.
`timescale 1ns/10ps
`default_nettype none
module xfer_server_tb_top;
	logic ref_clk;
	logic rstn;
	logic instrDone;
	logic regWr;
	logic regRd;
	logic memAck;
	logic busy;
	logic irq;
	logic [15:0] intReq;
	logic [15:0] regWdata;
	logic [15:0] regRdata;
	logic [15:0] memRdata;
	logic [15:0] rd;
	logic [3:0] regAddr;
	logic [3:0] lag;
	xfer_server_pkg::mem_req_type memReq;
	int badCount;
	int compares;
	xfer_server i_xfer_server (.ref_clk(ref_clk), .rstn(rstn),
		.intReq(intReq), .instrDone(instrDone), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .memReq(memReq), .memAck(memAck),
		.memRdata(memRdata), .busy(busy), .irq(irq));
	xfer_mem_model i_xfer_mem_model (.ref_clk(ref_clk), .memReq(memReq),
		.lag(lag), .memAck(memAck), .memRdata(memRdata));
	// Closing report and verdict.
	task automatic reportAndStop;
		$display("compares %0d errors %0d", compares, badCount);
		if (badCount == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : reportAndStop
	// Compare one value.
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			badCount++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// Memory access helpers behind the partner.
	task automatic pb(logic [15:0] a, logic [7:0] d);
		i_xfer_mem_model.mem[a] = d;
	endtask : pb
	task automatic pw(logic [15:0] a, logic [15:0] d);
		pb(a, d[7:0]);
		pb(a + 16'h1, d[15:8]);
	endtask : pw
	function automatic logic [15:0] pk(logic [15:0] a);
		return {i_xfer_mem_model.mem[a + 16'h1], i_xfer_mem_model.mem[a]};
	endfunction : pk
	// Register port cycles.
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge ref_clk);
		regWr <= 1'h0;
		#1;
	endtask : wr
	task automatic rdr(logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge ref_clk);
		regRd <= 1'h0;
		#1;
		d = regRdata;
	endtask : rdr
	// Bounded wait for busy to reach a level.
	task automatic waitFor(logic v, int n);
		for (int i = 0; i < n && busy !== v; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("busy", {15'h0, v}, {15'h0, busy});
		if (busy !== v) reportAndStop;
	endtask : waitFor
	// Vector, control block and select bit, in that order.
	task automatic setup(int s, logic [15:0] b, logic [7:0] c,
		logic [7:0] k, logic [15:0] sp, logic [15:0] dp, logic [7:0] n);
		wr(4'h8, {s[3:0], b[11:0]});
		pb(b, c);
		pb(b + 16'h1, k);
		pw(b + 16'h2, sp);
		pw(b + 16'h4, dp);
		pb(b + 16'h6, n);
		rdr(4'h0, rd);
		wr(4'h0, rd | (16'h1 << s));
	endtask : setup
	task automatic pulse(int s);
		@(posedge ref_clk);
		intReq[s] <= 1'h1;
		@(posedge ref_clk);
		intReq[s] <= 1'h0;
	endtask : pulse
	task automatic serve(int s);
		pulse(s);
		waitFor(1'h1, 60);
		waitFor(1'h0, 3000);
	endtask : serve
	// Word block with source write-back only, two requests.
	task automatic tWord;
		for (int i = 0; i < 16; i++) pw(16'h0100 + 16'(2 * i), 16'hc000 + 16'(i));
		setup(14, 16'h00e0, 8'h02, 8'h0b, 16'h0100, 16'h0400, 8'h08);
		wr(4'h2, 16'hffff);
		wr(4'h6, 16'h0003);
		wr(4'h3, 16'h0003);
		for (int k = 0; k < 2; k++) begin
			lag <= 4'(3 * k);
			serve(14);
			for (int i = 0; i < 8; i++) chk("dst", 16'hc000 + 16'(8 * k + i), pk(16'h0400 + 16'(2 * i)));
			chk("cnt", 16'(1 - k), {8'h0, i_xfer_mem_model.mem[16'h00e0]});
			chk("src", 16'h0110 + 16'(16 * k), pk(16'h00e2));
			chk("dptr", 16'h0400, pk(16'h00e4));
		end
		rdr(4'h0, rd);
		chk("sel", 16'h0, rd & 16'h4000);
		rdr(4'h1, rd);
		chk("pend", 16'h4000, rd & 16'h4000);
		chk("irq", 16'h1, {15'h0, irq});
		wr(4'h6, 16'h0000);
		chk("irqm", 16'h0, {15'h0, irq});
		wr(4'h6, 16'h0003);
		rdr(4'h5, rd);
		chk("ist", 16'h1, rd & 16'h1);
		chk("irqc", 16'h0, {15'h0, irq});
	endtask : tWord
	// Byte block of the largest burst, destination write-back only.
	task automatic tByte;
		pb(16'h0300, 8'h5a);
		pb(16'h0301, 8'h77);
		pb(16'h0520, 8'h00);
		setup(3, 16'h0200, 8'h01, 8'h15, 16'h0300, 16'h0500, 8'h20);
		serve(3);
		for (int i = 0; i < 32; i++) chk("byte", 16'h5a, {8'h0, i_xfer_mem_model.mem[16'h0500 + 16'(i)]});
		chk("edge", 16'h0, {8'h0, i_xfer_mem_model.mem[16'h0520]});
		chk("dwb", 16'h0520, pk(16'h0204));
		chk("sfix", 16'h0300, pk(16'h0202));
	endtask : tByte
	// Shared capture/compare source and unselected source stay unserved.
	task automatic tRefuse;
		logic seen;
		seen = 1'h0;
		wr(4'h1, 16'hffff);
		setup(0, 16'h0280, 8'h01, 8'h0b, 16'h0300, 16'h0600, 8'h01);
		pulse(0);
		pulse(5);
		repeat (60) begin
			@(posedge ref_clk);
			#1;
			seen = seen | busy;
		end
		chk("refuse", 16'h0, {15'h0, seen});
		rdr(4'h7, rd);
		chk("unmap", 16'h0, rd);
	endtask : tRefuse
	// Start waits for instruction end; a second request waits for the burst.
	task automatic tLatency;
		int i;
		setup(14, 16'h00e0, 8'h02, 8'h0b, 16'h0100, 16'h0400, 8'h08);
		setup(3, 16'h0200, 8'h01, 8'h15, 16'h0300, 16'h0500, 8'h01);
		@(posedge ref_clk);
		instrDone <= 1'h0;
		pulse(14);
		repeat (20) @(posedge ref_clk);
		instrDone <= 1'h1;
		// Look after the edge has settled; the server is still waiting.
		#1;
		chk("early", 16'h0, {15'h0, memReq.read});
		for (i = 0; i < 50 && memReq.read !== 1'h1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("lat", 16'h1, {15'h0, i <= xfer_server_pkg::LATENCY_CYCLES});
		if (i >= 50) reportAndStop;
		pulse(3);
		waitFor(1'h0, 3000);
		chk("c14", 16'h1, {8'h0, i_xfer_mem_model.mem[16'h00e0]});
		chk("c3", 16'h1, {8'h0, i_xfer_mem_model.mem[16'h0200]});
		waitFor(1'h1, 60);
		waitFor(1'h0, 3000);
		chk("c3d", 16'h0, {8'h0, i_xfer_mem_model.mem[16'h0200]});
	endtask : tLatency
	// A non-block mode moves nothing and leaves the count alone.
	task automatic tMode;
		pb(16'h0700, 8'h00);
		setup(3, 16'h0200, 8'h01, 8'h95, 16'h0300, 16'h0700, 8'h01);
		serve(3);
		chk("mode", 16'h0, {8'h0, i_xfer_mem_model.mem[16'h0700]});
		chk("mcnt", 16'h1, {8'h0, i_xfer_mem_model.mem[16'h0200]});
	endtask : tMode
	// Clock of 25 ns.
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Main sequence.
	initial begin
		rstn = 1'h0;
		instrDone = 1'h1;
		intReq = 16'h0;
		regAddr = 4'h0;
		regWdata = 16'h0;
		regWr = 1'h0;
		regRd = 1'h0;
		lag = 4'h0;
		badCount = 0;
		compares = 0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'h1;
		tWord;
		tByte;
		tRefuse;
		tLatency;
		tMode;
		reportAndStop;
	end
endmodule : xfer_server_tb_top
`default_nettype wire
